//--- rtl/fcs_defines.vh
// constants for the completion-state handler
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
`define FCS_ADDR_STATUS      4'h0
`define FCS_ADDR_DATA        4'h1
`define FCS_ADDR_IRQ_STS     4'h2
`define FCS_ADDR_IRQ_MASK    4'h3
`define FCS_ADDR_RSP_LEN     4'h4
`define FCS_ADDR_CTRL        4'h5
`define FCS_BIT_RESEND       1
`define FCS_BIT_EXEC         5
`define FCS_BIT_AVAIL        4
`define FCS_BIT_HOST_RDY     6
`define FCS_IRQ_GOOD         0
`define FCS_IRQ_AVAIL        1
`define FCS_IRQ_IDLE         2
`define FCS_IRQ_DROP         3
`define FCS_IRQ_W            4
`define FCS_ST_IDLE          3'h0
`define FCS_ST_READY         3'h1
`define FCS_ST_RECEPTION     3'h2
`define FCS_ST_EXECUTION     3'h3
`define FCS_ST_COMPLETION    3'h4
`define FCS_EMPTY_BYTE       8'hFF
`define FCS_RSP_DEPTH        64
`define FCS_PTR_W            6
`endif

//--- rtl/fcs_rsp_mem.v
// response byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module fcs_rsp_mem #(
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire          clk_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [7:0]    wr_data_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [7:0]    rd_data_out
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clk_in)
    begin
        if (wr_en_in)
            mem[wr_addr_in] <= wr_data_in;
        rd_data_out <= mem[rd_addr_in];
    end
endmodule
`default_nettype wire

//--- rtl/fcs_completion.v
// completion-state handler of the fifo interface status machine
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module fcs_completion #(
    parameter DEPTH = `FCS_RSP_DEPTH,
    parameter AW    = `FCS_PTR_W
) (
    input  wire          clk_in,
    input  wire          rst_b_in,
    input  wire [3:0]    addr_in,
    input  wire [7:0]    wdata_in,
    input  wire          wr_in,
    input  wire          rd_in,
    output reg  [7:0]    rdata_out,
    input  wire          exec_done_in,
    input  wire          rsp_wr_in,
    input  wire [AW-1:0] rsp_waddr_in,
    input  wire [7:0]    rsp_wdata_in,
    output reg  [2:0]    state_out,
    output wire          response_available_out,
    output wire          irq_out
);
    reg [2:0]    state;
    reg [2:0]    next_state;
    reg          response_available;
    reg          next_response_available;
    reg [AW-1:0] response_read_pointer;
    reg [AW-1:0] next_response_read_pointer;
    reg [AW:0]   rsp_len;
    reg [`FCS_IRQ_W-1:0] irq_sts;
    reg [`FCS_IRQ_W-1:0] irq_mask;
    reg [`FCS_IRQ_W-1:0] irq_set;
    reg          auto_ready;
    wire [7:0]   mem_rdata;

    // one-hot test of the three command fields
    function is_only;
        input [7:0] d;
        input integer b;
        begin
            is_only = d[b] &&
                ((d[`FCS_BIT_RESEND] + d[`FCS_BIT_EXEC] +
                  d[`FCS_BIT_HOST_RDY]) == 1);
        end
    endfunction

    // one write strobe decoded against one register offset
    function wr_hit;
        input       strobe;
        input [3:0] addr;
        input [3:0] target;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    // status byte: response_available at its field, state in the low bits
    function [7:0] status_byte;
        input       avail;
        input [2:0] st;
        begin
            status_byte = 8'h00;
            status_byte[`FCS_BIT_AVAIL] = avail;
            status_byte[2:0] = st;
        end
    endfunction

    wire sts_wr      = wr_hit(wr_in, addr_in, `FCS_ADDR_STATUS);
    wire data_wr     = wr_hit(wr_in, addr_in, `FCS_ADDR_DATA);
    wire irq_sts_wr  = wr_hit(wr_in, addr_in, `FCS_ADDR_IRQ_STS);
    wire irq_mask_wr = wr_hit(wr_in, addr_in, `FCS_ADDR_IRQ_MASK);
    wire rsp_len_wr  = wr_hit(wr_in, addr_in, `FCS_ADDR_RSP_LEN);
    wire ctrl_wr     = wr_hit(wr_in, addr_in, `FCS_ADDR_CTRL);
    wire data_rd     = rd_in && (addr_in == `FCS_ADDR_DATA);
    wire in_comp     = (state == `FCS_ST_COMPLETION);
    wire pending     = in_comp && response_available;
    wire last_rd     = data_rd && pending &&
                   ({1'b0, response_read_pointer} + {{AW{1'b0}}, 1'b1}
                    >= rsp_len);

    // the memory is addressed with the pointer's next value, so its
    // registered output already holds the byte at the current pointer
    // when a read strobe comes; back-to-back reads need no wait
    fcs_rsp_mem #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk_in      (clk_in),
        .wr_en_in    (rsp_wr_in),
        .wr_addr_in  (rsp_waddr_in),
        .wr_data_in  (rsp_wdata_in),
        .rd_addr_in  (next_response_read_pointer),
        .rd_data_out (mem_rdata)
    );

    always @*
    begin
        next_state = state;
        next_response_available = response_available;
        next_response_read_pointer = response_read_pointer;
        irq_set = {`FCS_IRQ_W{1'b0}};
        // execution is owned by the neighbouring states; the finish pulse
        // is taken in any state so a response can never be stranded
        if (exec_done_in)
        begin
            next_state = `FCS_ST_COMPLETION;
            next_response_available = 1'b1;
            next_response_read_pointer = {AW{1'b0}};
            irq_set[`FCS_IRQ_AVAIL] = 1'b1;
        end
        // optional hop from idle straight on to ready, set by the control bit
        else if (state == `FCS_ST_IDLE && auto_ready)
            next_state = `FCS_ST_READY;
        else if (in_comp)
        begin
            if (response_available)
            begin
                // execute_trigger and data writes fall through
                if (last_rd)
                begin
                    next_response_available = 1'b0;
                    irq_set[`FCS_IRQ_GOOD] = 1'b1;
                end
                // pointer may run past the end; a rewind comes with resend
                if (data_rd)
                    next_response_read_pointer =
                        response_read_pointer + {{(AW-1){1'b0}}, 1'b1};
            end
            else if (sts_wr)
            begin
                // multi-field writes are ignored here
                if (is_only(wdata_in, `FCS_BIT_RESEND))
                begin
                    next_response_read_pointer = {AW{1'b0}};
                    next_response_available = 1'b1;
                    irq_set[`FCS_IRQ_AVAIL] = 1'b1;
                end
                else if (is_only(wdata_in, `FCS_BIT_HOST_RDY))
                begin
                    next_state = `FCS_ST_IDLE;
                    irq_set[`FCS_IRQ_IDLE] = 1'b1;
                end
                // execute_trigger alone changes nothing
            end
            else if (data_wr)
                irq_set[`FCS_IRQ_DROP] = 1'b1;
        end
    end

    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= `FCS_ST_IDLE;
            response_available <= 1'b0;
            response_read_pointer <= {AW{1'b0}};
            rsp_len <= {(AW+1){1'b0}};
            irq_sts <= {`FCS_IRQ_W{1'b0}};
            irq_mask <= {`FCS_IRQ_W{1'b0}};
            auto_ready <= 1'b0;
            rdata_out <= 8'h00;
            state_out <= `FCS_ST_IDLE;
        end
        else
        begin
            state <= next_state;
            state_out <= next_state;
            response_available <= next_response_available;
            response_read_pointer <= next_response_read_pointer;
            // set wins over a same-cycle write-one clear
            if (irq_sts_wr)
                irq_sts <= (irq_sts & ~wdata_in[`FCS_IRQ_W-1:0]) | irq_set;
            else
                irq_sts <= irq_sts | irq_set;
            if (irq_mask_wr)
                irq_mask <= wdata_in[`FCS_IRQ_W-1:0];
            // the top length bit stays clear: 63 bytes is the longest reply
            if (rsp_len_wr)
                rsp_len <= {1'b0, wdata_in[AW-1:0]};
            if (ctrl_wr)
                auto_ready <= wdata_in[0];
            if (rd_in)
            begin
                case (addr_in)
                    `FCS_ADDR_STATUS:
                        rdata_out <= status_byte(response_available, state);
                    // memory byte only while a response is pending
                    `FCS_ADDR_DATA:
                        rdata_out <= pending ? mem_rdata : `FCS_EMPTY_BYTE;
                    `FCS_ADDR_IRQ_STS:
                        rdata_out <= {{(8-`FCS_IRQ_W){1'b0}}, irq_sts};
                    `FCS_ADDR_IRQ_MASK:
                        rdata_out <= {{(8-`FCS_IRQ_W){1'b0}}, irq_mask};
                    `FCS_ADDR_RSP_LEN:
                        rdata_out <= {{(7-AW){1'b0}}, rsp_len};
                    `FCS_ADDR_CTRL:
                        rdata_out <= {7'h00, auto_ready};
                    default:
                        rdata_out <= 8'h00;
                endcase
            end
            else
                rdata_out <= 8'h00;
        end
    end

    assign response_available_out = response_available;
    // level interrupt, high while any unmasked status bit is set
    assign irq_out = |(irq_sts & irq_mask);
endmodule
`default_nettype wire

//--- tb/fcs_completion_assertions.sv
// port checker for the completion-state handler
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module fcs_chk (
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       exec_done_in,
    input wire logic [2:0] state_out,
    input wire logic       response_available_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire cmp = state_out == `FCS_ST_COMPLETION;
    wire full = cmp && response_available_out;
    wire dry = cmp && !response_available_out;
    wire sts = wr_in && addr_in == `FCS_ADDR_STATUS;
    wire dat = addr_in == `FCS_ADDR_DATA;
    logic [6:0] len_q;
    logic [6:0] rd_cnt;
    // bytes read since the response was last armed, for the final-byte check
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            len_q <= 7'h00;
            rd_cnt <= 7'h00;
        end
        else
        begin
            if (wr_in && addr_in == `FCS_ADDR_RSP_LEN)
                len_q <= {1'b0, wdata_in[`FCS_PTR_W-1:0]};
            if (exec_done_in || (dry && sts && wdata_in == 8'h02))
                rd_cnt <= 7'h00;
            else if (full && rd_in && dat)
                rd_cnt <= rd_cnt + 7'h01;
        end
    end
    sequence s_final_read;
        full && rd_in && dat && (rd_cnt + 7'h01 >= len_q);
    endsequence
    sequence s_inner_read;
        full && rd_in && dat && (rd_cnt + 7'h01 < len_q);
    endsequence
    AST_LAST_READ: assert property (s_final_read |=> dry)
        else $error("final byte kept data pending");
    AST_INNER_READ: assert property (s_inner_read |=> full)
        else $error("early byte ended the response");
    AST_FINISH: assert property (exec_done_in |=> full)
        else $error("finish missed completion");
    AST_RESEND: assert property (dry && sts && wdata_in == 8'h02 |=> full)
        else $error("resend did not rearm");
    AST_EXEC_DRY: assert property (dry && sts && wdata_in == 8'h20
        |=> $stable(state_out) && !response_available_out)
        else $error("trigger not ignored");
    AST_TO_IDLE: assert property (dry && sts && wdata_in == 8'h40
        |=> state_out inside {`FCS_ST_IDLE, `FCS_ST_READY})
        else $error("host ready did not leave");
    AST_DROP_DRY: assert property (dry && wr_in && dat |=> dry)
        else $error("dry data write acted");
    AST_EMPTY_RD: assert property (dry && rd_in && dat |=> rdata_out == 8'hFF)
        else $error("dry read not empty byte");
    AST_EXEC_FULL: assert property (full && sts && wdata_in == 8'h20
        |=> full)
        else $error("trigger changed state");
    AST_DROP_FULL: assert property (full && wr_in && dat |=> full)
        else $error("data write acted");
endmodule
bind fcs_completion fcs_chk i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .exec_done_in(exec_done_in),
    .state_out(state_out), .response_available_out(response_available_out));
`default_nettype wire

//--- tb/fcs_engine_model.sv
// engine model: fills the response memory, then signals finish
`timescale 1ns/1ps
`default_nettype none
module fcs_engine_model (
    input  wire logic       clk_in,
    output var  logic       done_out,
    output var  logic       we_out,
    output var  logic [5:0] wa_out,
    output var  logic [7:0] wd_out
);
    initial {done_out, we_out, wa_out, wd_out} = '0;
    // byte i is 8'hA0 + i so the bench can predict it
    task automatic load(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            we_out <= 1'b1;
            wa_out <= 6'(i);
            wd_out <= 8'hA0 + 8'(i);
        end
        @(posedge clk_in);
        we_out <= 1'b0;
        wd_out <= ~wd_out;
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

//--- tb/fcs_completion_test.sv
// self-checking bench of the completion-state handler
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module fcs_completion_test;
    logic       clk_in, rst_b_in, wr_in, rd_in;
    logic [3:0] addr_in;
    logic [7:0] wdata_in, got;
    wire  [7:0] rdata_out, wd;
    wire  [5:0] wa;
    wire  [2:0] state_out;
    wire        avail, irq, done, we;
    int         errors = 0, compares = 0;
    localparam logic [3:0] ST = `FCS_ADDR_STATUS, DT = `FCS_ADDR_DATA;
    localparam logic [2:0] CM = `FCS_ST_COMPLETION;
    fcs_completion i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .exec_done_in(done),
        .rsp_wr_in(we), .rsp_waddr_in(wa), .rsp_wdata_in(wd),
        .state_out(state_out), .response_available_out(avail),
        .irq_out(irq));
    fcs_engine_model i_eng (.clk_in(clk_in), .done_out(done), .we_out(we),
        .wa_out(wa), .wd_out(wd));
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask
    task automatic chk(input logic [7:0] g, e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cs(input logic [3:0] e);
        chk({4'h0, state_out, avail}, {4'h0, e});
    endtask
    task automatic t_full;
        wr(`FCS_ADDR_RSP_LEN, 8'h03);
        i_eng.load(3);
        cs({CM, 1'b1});
        rd(ST);
        chk(got, 8'h14);
        wr(ST, 8'h20);
        wr(DT, 8'h5A);
        cs({CM, 1'b1});
    endtask
    task automatic t_read;
        for (int i = 0; i < 3; i++)
        begin
            rd(DT);
            chk(got, 8'hA0 + 8'(i));
        end
        cs({CM, 1'b0});
    endtask
    task automatic t_dry;
        rd(DT);
        chk(got, 8'hFF);
        wr(DT, 8'h11);
        wr(ST, 8'h20);
        cs({CM, 1'b0});
        rd(ST);
        chk(got, 8'h04);
        wr(ST, 8'h02);
        cs({CM, 1'b1});
    endtask
    // events so far set good-transfer, available and dropped-write bits
    task automatic t_irq;
        wr(`FCS_ADDR_IRQ_MASK, 8'h00);
        chk({7'h0, irq}, 8'h00);
        rd(`FCS_ADDR_IRQ_STS);
        chk(got, 8'h0B);
        wr(`FCS_ADDR_IRQ_MASK, 8'h08);
        chk({7'h0, irq}, 8'h01);
        rd(`FCS_ADDR_IRQ_MASK);
        chk(got, 8'h08);
        wr(`FCS_ADDR_IRQ_STS, 8'h07);
        chk({7'h0, irq}, 8'h01);
        wr(`FCS_ADDR_IRQ_STS, 8'h08);
        rd(`FCS_ADDR_IRQ_STS);
        chk(got, 8'h00);
        chk({7'h0, irq}, 8'h00);
        rd(`FCS_ADDR_RSP_LEN);
        chk(got, 8'h03);
        rd(4'hF);
        chk(got, 8'h00);
    endtask
    task automatic t_idle;
        wr(ST, 8'h40);
        cs({`FCS_ST_IDLE, 1'b0});
        wr(`FCS_ADDR_CTRL, 8'h01);
        i_eng.load(3);
        cs({CM, 1'b1});
        t_read;
        wr(ST, 8'h40);
        cs({`FCS_ST_IDLE, 1'b0});
        @(posedge clk_in);
        #1 cs({`FCS_ST_READY, 1'b0});
    endtask
    task automatic stop_test;
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        {wr_in, rd_in, addr_in, wdata_in} = '0;
        rst_b_in = 1'b0;
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_full;
        t_read;
        t_dry;
        t_read;
        t_irq;
        t_idle;
        stop_test;
    end
endmodule
`default_nettype wire
